//--- verilog/vsw_map.svh
`ifndef VSW_MAP_SVH
`define VSW_MAP_SVH
// register byte indices as printed; byte address is four times the index
`define VSW_IDX_VOFS_LO   8'h35
`define VSW_IDX_VOFS_HI   8'h36
`define VSW_IDX_HOFS_LO   8'h37
`define VSW_IDX_HOFS_HI   8'h38
`define VSW_IDX_VLEN_LO   8'h39
`define VSW_IDX_VLEN_HI   8'h40
`define VSW_IDX_HLEN_LO   8'h41
`define VSW_IDX_HLEN_HI   8'h42
`define VSW_IDX_CLMP_BEG  8'h43
`define VSW_IDX_CLMP_END  8'h44
`define VSW_IDX_GAIN_BEG  8'h45
`define VSW_IDX_GAIN_END  8'h46
`define VSW_IDX_CTRL      8'h47
`define VSW_IDX_STATUS    8'h48
// control field positions
`define VSW_CTRL_HPOL     0
`define VSW_CTRL_VPOL     1
`define VSW_CTRL_CPOL     2
`define VSW_CTRL_GPOL     3
`define VSW_CTRL_SEQ      4
`define VSW_CTRL_EN       5
// reset values
`define VSW_CTRL_RST      8'h00
`define VSW_BYTE_RST      8'h00
`endif

//--- verilog/vsw_pkg.sv
package vsw_pkg;
    typedef logic [1:0] vsw_resp_t;
    typedef enum logic [1:0] {
        VSW_IDLE = 2'b00,
        VSW_RESP = 2'b01
    } vsw_bus_e;
endpackage

//--- verilog/vsw_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface vsw_sync_if;
    logic line_start;
    logic frame_start;
    modport src (output line_start, output frame_start);
    modport dst (input line_start, input frame_start);
endinterface
`default_nettype wire

//--- verilog/vsw_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none
module vsw_sync_edge (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // pins and polarity
    input  wire logic line_sync_pin,
    input  wire logic frame_sync_pin,
    input  wire logic hpol,
    input  wire logic vpol,
    // line and frame start pulses
    vsw_sync_if.src   sy
);
    logic [1:0] h_meta_r;
    logic [1:0] v_meta_r;
    logic       h_prev_r;
    logic       v_prev_r;
    logic [2:0] arm_r;
    wire        armed = arm_r[2];
    wire        h_now = h_meta_r[1];
    wire        v_now = v_meta_r[1];
    // start edge: rising when active low, falling when active high
    // masked until the history has settled, so reset makes no false edge
    assign sy.line_start  = armed & (hpol ? (h_prev_r & ~h_now)
                                          : (~h_prev_r & h_now)); // [RL12]
    assign sy.frame_start = armed & (vpol ? (v_prev_r & ~v_now)
                                          : (~v_prev_r & v_now)); // [RL13]
    // two-stage synchronisers then edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            h_meta_r <= 2'h0;
            v_meta_r <= 2'h0;
            h_prev_r <= 1'b0;
            v_prev_r <= 1'b0;
            arm_r    <= 3'h0;
        end else begin
            arm_r    <= {arm_r[1:0], 1'b1};
            h_meta_r <= {h_meta_r[0], line_sync_pin};
            v_meta_r <= {v_meta_r[0], frame_sync_pin};
            h_prev_r <= h_now;
            v_prev_r <= v_now;
        end
    end
endmodule // vsw_sync_edge
`default_nettype wire

//--- verilog/vsw_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "vsw_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// RL1 - control bit 3 makes the gain pulse active low at 0, high at 1.
// RL2 - sequence bit picks ADC 0 or ADC 1 as first sample after line sync.
// RL3 - enable bit cleared stops all sampling, set allows it.
// RL4 - window starts an 11-bit line offset after frame sync.
// RL5 - window starts a 12-bit sample offset after line sync.
// RL6 - window height is an 11-bit line count.
// RL7 - window width is a 12-bit sample count.
// RL8 - clamp pulse begins an 8-bit count after the line sync edge.
// RL9 - clamp pulse ends an 8-bit count after the line sync edge.
// RL10 - gain pulse begins an 8-bit delay after the line sync edge.
// RL11 - gain pulse ends at its own 8-bit delay after the line sync edge.
// RL12 - line sync polarity 0 starts lines at rising edge, 1 at falling.
// RL13 - frame sync polarity 0 starts frames at rising edge, 1 at falling.
// RL14 - control bit 2 sets the clamp pulse polarity.
// RL15 - horizontal counts in clocks, vertical in lines, reset at sync.
// RL16 - samples pass only inside both window ranges while enabled.
module vsw_top #(
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output vsw_pkg::vsw_resp_t        s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output vsw_pkg::vsw_resp_t        s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // video pins
    input  wire logic                 line_sync_pin,
    input  wire logic                 frame_sync_pin,
    input  wire logic [3*DW-1:0]      adc0_data,
    input  wire logic [3*DW-1:0]      adc1_data,
    // converter pulses
    output logic                      clamp_pulse,
    output logic                      gain_correction_pulse,
    // sampled stream
    output logic [3*DW-1:0]           pix_data,
    output logic                      pix_valid,
    output logic                      pix_from_adc1
);
    import vsw_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic [7:0] vsw_idx(input logic [11:0] a);
        vsw_idx = a[9:2];
    endfunction

    function automatic logic vsw_known(input logic [7:0] i);
        vsw_known = (i >= `VSW_IDX_VOFS_LO) && (i <= `VSW_IDX_STATUS);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  vofs_lo_r, vofs_hi_r, hofs_lo_r, hofs_hi_r;
    logic [7:0]  vlen_lo_r, vlen_hi_r, hlen_lo_r, hlen_hi_r;
    logic [7:0]  clmp_beg_r, clmp_end_r, gain_beg_r, gain_end_r;
    logic [7:0]  ctrl_r;
    logic [11:0] awaddr_r;
    logic [7:0]  wbyte_r;
    logic        aw_got_r, w_got_r;
    logic [11:0] araddr_r;
    vsw_bus_e    wst_r, rst_r;

    // merged fields
    wire [10:0] vofs = {vofs_hi_r[2:0], vofs_lo_r}; // [RL4]
    wire [11:0] hofs = {hofs_hi_r[3:0], hofs_lo_r}; // [RL5]
    wire [10:0] vlen = {vlen_hi_r[2:0], vlen_lo_r}; // [RL6]
    wire [11:0] hlen = {hlen_hi_r[3:0], hlen_lo_r}; // [RL7]
    wire hpol = ctrl_r[`VSW_CTRL_HPOL];
    wire vpol = ctrl_r[`VSW_CTRL_VPOL];
    wire cpol = ctrl_r[`VSW_CTRL_CPOL];
    wire gpol = ctrl_r[`VSW_CTRL_GPOL];
    wire seq  = ctrl_r[`VSW_CTRL_SEQ];
    wire en   = ctrl_r[`VSW_CTRL_EN];

    //////////////////////////////////////////////////////////////////////////
    // sync edges
    vsw_sync_if sy ();

    vsw_sync_edge u_edge (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .line_sync_pin  (line_sync_pin),
        .frame_sync_pin (frame_sync_pin),
        .hpol           (hpol),
        .vpol           (vpol),
        .sy             (sy)
    );

    //////////////////////////////////////////////////////////////////////////
    // write channel
    wire       w_fire  = aw_got_r & w_got_r & (wst_r == VSW_IDLE);
    wire [7:0] w_idx   = vsw_idx(awaddr_r);
    wire       w_ok    = vsw_known(w_idx) && (w_idx != `VSW_IDX_STATUS);
    // next handshake state, so the ready outputs come from flops
    wire       aw_hs      = s_axi_awvalid & s_axi_awready;
    wire       w_hs       = s_axi_wvalid & s_axi_wready;
    wire       b_done     = s_axi_bvalid & s_axi_bready;
    wire       aw_got_nxt = ~w_fire & (aw_got_r | aw_hs);
    wire       w_got_nxt  = ~w_fire & (w_got_r | w_hs);
    wire       w_idle_nxt = w_fire ? 1'b0 : (b_done | (wst_r == VSW_IDLE));

    // address and data taken in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 12'h000;
            wbyte_r  <= 8'h00;
            wst_r    <= VSW_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_got_nxt & w_idle_nxt;
            s_axi_wready  <= ~w_got_nxt & w_idle_nxt;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wbyte_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            end
            if (w_fire) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                wst_r        <= VSW_RESP;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                wst_r        <= VSW_IDLE;
            end
        end
    end


    // register store, low byte lane only
    wire       w_st = w_fire & w_ok;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vofs_lo_r <= `VSW_BYTE_RST; vofs_hi_r <= `VSW_BYTE_RST;
            hofs_lo_r <= `VSW_BYTE_RST; hofs_hi_r <= `VSW_BYTE_RST;
            vlen_lo_r <= `VSW_BYTE_RST; vlen_hi_r <= `VSW_BYTE_RST;
            hlen_lo_r <= `VSW_BYTE_RST; hlen_hi_r <= `VSW_BYTE_RST;
            clmp_beg_r <= `VSW_BYTE_RST; clmp_end_r <= `VSW_BYTE_RST;
            gain_beg_r <= `VSW_BYTE_RST; gain_end_r <= `VSW_BYTE_RST;
            ctrl_r <= `VSW_CTRL_RST;
        end else if (w_st) begin
            case (w_idx)
                `VSW_IDX_VOFS_LO:  vofs_lo_r  <= wbyte_r;
                `VSW_IDX_VOFS_HI:  vofs_hi_r  <= wbyte_r;
                `VSW_IDX_HOFS_LO:  hofs_lo_r  <= wbyte_r;
                `VSW_IDX_HOFS_HI:  hofs_hi_r  <= wbyte_r;
                `VSW_IDX_VLEN_LO:  vlen_lo_r  <= wbyte_r;
                `VSW_IDX_VLEN_HI:  vlen_hi_r  <= wbyte_r;
                `VSW_IDX_HLEN_LO:  hlen_lo_r  <= wbyte_r;
                `VSW_IDX_HLEN_HI:  hlen_hi_r  <= wbyte_r;
                `VSW_IDX_CLMP_BEG: clmp_beg_r <= wbyte_r; // [RL8]
                `VSW_IDX_CLMP_END: clmp_end_r <= wbyte_r; // [RL9]
                `VSW_IDX_GAIN_BEG: gain_beg_r <= wbyte_r; // [RL10]
                `VSW_IDX_GAIN_END: gain_end_r <= wbyte_r; // [RL11]
                `VSW_IDX_CTRL:     ctrl_r     <= wbyte_r;
                default:           ctrl_r     <= ctrl_r;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read channel
    logic [10:0] vcnt_r;
    logic [11:0] hcnt_r;
    logic        frame_seen_r;
    wire [7:0]  r_idx  = vsw_idx(araddr_r);
    wire        r_ctrl = (r_idx == `VSW_IDX_CTRL);
    wire        r_stat = (r_idx == `VSW_IDX_STATUS);
    wire        r_ok   = vsw_known(r_idx);
    wire [31:0] r_word = r_ctrl ? {24'h000000, ctrl_r} :
                         r_stat ? {4'h0, hcnt_r, 4'h0, vcnt_r,
                                   frame_seen_r} : 32'h00000000;
    // read acceptance for the next cycle, registered into arready
    wire        ar_hs      = s_axi_arvalid & s_axi_arready;
    wire        r_idle_nxt = (rst_r == VSW_IDLE) ? ~ar_hs
                                                 : (s_axi_rvalid & s_axi_rready);

    // write-only bytes read zero; indices outside 0x35 to 0x48 answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            araddr_r     <= 12'h000;
            rst_r        <= VSW_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= r_idle_nxt;
            if (rst_r == VSW_IDLE) begin
                if (ar_hs) begin
                    araddr_r <= s_axi_araddr;
                    rst_r    <= VSW_RESP;
                end
            end else if (!s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= r_word;
                s_axi_rresp  <= r_ok ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                rst_r        <= VSW_IDLE;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // line and frame counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hcnt_r       <= 12'h000;
            vcnt_r       <= 11'h000;
            frame_seen_r <= 1'b0;
        end else begin
            if (sy.line_start)
                hcnt_r <= 12'h000; // [RL15]
            else if (hcnt_r != 12'hfff)
                hcnt_r <= hcnt_r + 12'h001;
            if (sy.frame_start) begin
                vcnt_r       <= 11'h000; // [RL15]
                frame_seen_r <= 1'b1;
            end else if (sy.line_start && vcnt_r != 11'h7ff)
                vcnt_r <= vcnt_r + 11'h001;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // window and pulse decode
    wire [12:0] h_end = {1'b0, hofs} + {1'b0, hlen};
    wire [11:0] v_end = {1'b0, vofs} + {1'b0, vlen};
    wire in_h = ({1'b0, hcnt_r} >= {1'b0, hofs}) &&
                ({1'b0, hcnt_r} < h_end);
    wire in_v = ({1'b0, vcnt_r} >= {1'b0, vofs}) &&
                ({1'b0, vcnt_r} < v_end);
    wire take = en & in_h & in_v; // [RL3] [RL16]
    wire h_hi = (hcnt_r[11:8] != 4'h0);
    wire clmp_on = ~h_hi && (hcnt_r[7:0] >= clmp_beg_r) &&
                   (hcnt_r[7:0] < clmp_end_r);
    wire gain_on = ~h_hi && (hcnt_r[7:0] >= gain_beg_r) &&
                   (hcnt_r[7:0] < gain_end_r);
    // alternate converters, first pick by sequence bit
    wire odd  = hcnt_r[0] ^ hofs[0];
    wire pick = seq ^ odd; // [RL2]

    // registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clamp_pulse           <= 1'b0;
            gain_correction_pulse <= 1'b0;
            pix_valid             <= 1'b0;
            pix_data              <= '0;
            pix_from_adc1         <= 1'b0;
        end else begin
            clamp_pulse           <= clmp_on ~^ cpol; // [RL14]
            gain_correction_pulse <= gain_on ~^ gpol; // [RL1]
            pix_valid             <= take;
            pix_from_adc1         <= take & pick;
            if (take)
                pix_data <= pick ? adc1_data : adc0_data;
        end
    end

endmodule // vsw_top
`default_nettype wire

//--- testbench/vsw_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module vsw_top_asserts #(
    parameter int DW = 8
) (
    // clock and reset
    input wire logic            aclk,
    input wire logic            aresetn,
    // bus handshakes
    input wire logic            s_axi_awvalid,
    input wire logic            s_axi_awready,
    input wire logic            s_axi_wvalid,
    input wire logic            s_axi_wready,
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire vsw_pkg::vsw_resp_t s_axi_bresp,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [31:0]     s_axi_rdata,
    // samples
    input wire logic [3*DW-1:0] adc0_data,
    input wire logic [3*DW-1:0] adc1_data,
    input wire logic [3*DW-1:0] pix_data,
    input wire logic            pix_valid,
    input wire logic            pix_from_adc1
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // bus transfer steps
    sequence aw_take; s_axi_awvalid && s_axi_awready; endsequence
    sequence w_take; s_axi_wvalid && s_axi_wready; endsequence
    sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid lost");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid lost");
    a_write_answer: assert property (aw_take and w_take
        |-> ##[1:2] s_axi_bvalid) else $error("no write response");
    a_read_answer: assert property (ar_take |-> ##[1:2] s_axi_rvalid)
        else $error("no read response");
    a_write_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
    a_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("bvalid stuck");
    a_pix_alternate: assert property (
        pix_valid && $past(pix_valid) |-> pix_from_adc1 != $past(pix_from_adc1))
        else $error("source did not alternate");
    a_pix_source: assert property (
        pix_valid |-> pix_data == (pix_from_adc1 ? $past(adc1_data)
        : $past(adc0_data))) else $error("sample from wrong converter");
endmodule // vsw_top_asserts
bind vsw_top vsw_top_asserts #(.DW(DW)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .adc0_data(adc0_data), .adc1_data(adc1_data), .pix_data(pix_data),
    .pix_valid(pix_valid), .pix_from_adc1(pix_from_adc1));
`default_nettype wire

//--- testbench/vsw_vid_src.sv
`timescale 1ns/100ps
`default_nettype none
module vsw_vid_src #(
    parameter int LP = 320,
    parameter int SW = 8
) (
    // clock and reset
    input wire logic   aclk,
    input wire logic   aresetn,
    // pin polarities
    input wire logic   hpol,
    input wire logic   vpol,
    // sync pins and samples
    output logic        line_sync_pin,
    output logic        frame_sync_pin,
    output logic [23:0] adc0_data,
    output logic [23:0] adc1_data,
    // trailing sync edges for the bench
    output logic        line_mark,
    output logic        frame_mark
);
    int h;
    logic [15:0] v;
    // free-running raster, eight lines a frame
    always_ff @(posedge aclk) begin
        h <= (!aresetn || h == LP - 1) ? 0 : h + 1;
        v <= !aresetn ? 16'h0 : (h == LP - 1) ? {13'h0, v[2:0] + 3'h1} : v;
    end
    // pulse at the active level, line begins at its trailing edge
    assign line_sync_pin  = (h < SW) ? hpol : !hpol;
    assign frame_sync_pin = (v < 16'h2) ? vpol : !vpol;
    assign line_mark      = (h == SW);
    assign frame_mark     = (v == 16'h2) && (h == 0);
    // samples tagged by converter, changing every clock
    assign adc0_data = {8'h0a, 16'(h)};
    assign adc1_data = {8'hb1, 16'(h)};
endmodule // vsw_vid_src
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import vsw_pkg::*;
    // bench drive
    logic        aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0;
    logic        bri = 1'h0, arv = 1'h0, rri = 1'h0;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0;
    logic [3:0]  ws = '0;
    logic [7:0]  ctl = '0;
    // design and source outputs
    logic        awr, wrd, bv, arr, rv, clp, gn, pv, p1, hs, vs, lm, fm;
    vsw_resp_t   br, rr;
    logic [31:0] rdat;
    logic [23:0] a0, a1, pd;
    int errors, cmp_count, tick, ln, pc, cc, gc, tl, tc, dh, dv, po, go, fs;
    logic pp, cp, gp;
    logic [7:0] pf;
    always #5 aclk = ~aclk;
    vsw_vid_src src (.aclk(aclk), .aresetn(aresetn), .hpol(ctl[0]),
        .vpol(ctl[1]), .line_sync_pin(hs), .frame_sync_pin(vs),
        .adc0_data(a0), .adc1_data(a1), .line_mark(lm), .frame_mark(fm));
    vsw_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bri),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rri), .line_sync_pin(hs), .frame_sync_pin(vs),
        .adc0_data(a0), .adc1_data(a1), .clamp_pulse(clp),
        .gain_correction_pulse(gn), .pix_data(pd), .pix_valid(pv),
        .pix_from_adc1(p1));
    // pulse timing and counts against the raster
    always @(posedge aclk) begin
        tick++;
        if (fm) begin ln = 0; dv = -1; end
        if (lm) begin ln++; tl = tick; end
        if (clp === ctl[2] && !cp) begin tc = tick; dh = tick - tl; end
        if (gn === ctl[3] && !gp) go = tick - tc;
        if (pv === 1'h1 && !pp) begin
            po = tick - tc;
            fs = p1;
            pf = pd[23:16];
            if (dv < 0) dv = ln;
        end
        pp = (pv === 1'h1);
        cp = (clp === ctl[2]);
        gp = (gn === ctl[3]);
        pc += pp;
        cc += cp;
        gc += gp;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (e !== s) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // one write, aw and w offered together
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
        awa <= {2'h0, i, 2'h0};
        wd <= {24'h0, d};
        ws <= 4'h1;
        awv <= 1'h1;
        wv <= 1'h1;
        bri <= 1'h1;
        do begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'h0;
            if (wv && wrd) wv <= 1'h0;
        end while (bv !== 1'h1);
        bri <= 1'h0;
        chk("bresp", er, br);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] ed, input logic [1:0] er);
        ara <= {2'h0, i, 2'h0};
        arv <= 1'h1;
        rri <= 1'h1;
        do begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'h0;
        end while (rv !== 1'h1);
        rri <= 1'h0;
        if (er == 2'h0) chk("rdata", ed, rdat);
        chk("rresp", er, rr);
        @(posedge aclk);
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #600000;
        errors++;
        finish_test();
    end
    // main sequence
    initial begin
        int vl, hl, cb, ce, gb, ge;
        logic [7:0] cfg [4];
        logic [7:0] val [13];
        cfg = '{8'h20, 8'h3f, 8'h1c, 8'h36};
        void'($urandom(32'h0ae52334));
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        wr(8'h10, 8'h01, 2'h2);
        wr(8'h48, 8'h01, 2'h2);
        wr(8'h3a, 8'h55, 2'h0);
        rd(8'h10, 32'h0, 2'h2);
        for (int i = 0; i < 4; i++) begin
            vl = $urandom_range(1, 4);
            hl = $urandom_range(1, 16);
            cb = $urandom_range(0, 40);
            ce = cb + $urandom_range(1, 60);
            gb = cb + $urandom_range(1, 30);
            ge = gb + $urandom_range(1, 50);
            val = '{8'h03, 8'h00, 8'h05, 8'h01, 8'(vl), 8'h00, 8'(hl), 8'h00,
                    8'(cb), 8'(ce), 8'(gb), 8'(ge), cfg[i]};
            ctl <= cfg[i];
            for (int j = 0; j < 13; j++)
                wr((j < 5) ? 8'h35 + 8'(j) : 8'h3b + 8'(j), val[j], 2'h0);
            repeat (2) @(posedge fm);
            pc = 0;
            cc = 0;
            gc = 0;
            @(posedge fm);
            chk("pixels", cfg[i][5] ? vl * hl : 0, pc);
            chk("clamp", 8 * (ce - cb), cc);
            chk("gain", 8 * (ge - gb), gc);
            chk("gain ofs", gb - cb, go);
            if (cfg[i][5]) begin
                chk("pix ofs", 261 - cb, po);
                chk("first adc", cfg[i][4], fs);
                chk("first data", cfg[i][4] ? 8'hb1 : 8'h0a, pf);
                // three clocks to see the sync edge, one to register
                chk("line edge", 4, dh - cb);
                chk("frame edge", val[0], dv);
            end
        end
        rd(8'h35, 32'h0, 2'h0);
        rd(8'h41, 32'h0, 2'h0);
        rd(8'h47, {24'h0, cfg[3]}, 2'h0);
        finish_test();
    end
endmodule // tb
`default_nettype wire
